// ==== hw/wpf_params.svh ====
// Purpose: shared offsets, field positions, reset values and counts of the wake pattern filter store
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef WPF_PARAMS_SVH
`define WPF_PARAMS_SVH
// ==========================================================================
// store layout
`define WPF_NUM_FILTERS 8
`define WPF_NUM_WORDS 40
`define WPF_MASK_WORDS 4
`define WPF_MASK_BITS 128
`define WPF_CMD_BASE 6'd32
`define WPF_OFS_BASE 6'd34
`define WPF_CRC_BASE 6'd36
`define WPF_LAST_WORD 6'd39
`define WPF_CMD_KEEP 32'h0d0d0d0d
// ==========================================================================
// command fields
`define WPF_CMD_ENABLE_BIT 0
`define WPF_CMD_SCOPE_ANY_BIT 2
`define WPF_CMD_SCOPE_MC_BIT 3
// ==========================================================================
// pattern crc
`define WPF_CRC_POLY 16'h8005
`define WPF_CRC_INIT 16'hffff
`define WPF_INDEX_MAX 11'h7ff
// ==========================================================================
// register bus
`define WPF_ADDR_PORT 8'h00
`define WPF_ADDR_CTRL 8'h04
`define WPF_CTRL_REWIND_BIT 0
`define WPF_RESP_OKAY 2'b00
`define WPF_RESP_SLVERR 2'b10
`endif

// ==== hw/wpf_pkg.sv ====
// Purpose: types of the wake pattern filter store
// Assumes: nothing
// Notes: constants live in wpf_params.svh
package wpf_pkg;
  typedef logic [31:0] wpf_word_type;
  typedef logic [5:0] wpf_ptr_type;
  typedef logic [10:0] wpf_index_type;
  typedef logic [7:0] wpf_addr_type;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_ADDR = 2'b01,
    RD_FETCH = 2'b10,
    RD_RESP = 2'b11
  } wpf_rd_state_type;
endpackage

// ==== hw/wpf_if.sv ====
// Purpose: carriers between the top, the word store and the filter engines
// Assumes: one clock
// Notes: image is the whole store, word i at bits i*32 upward
`timescale 1ns/1ps
`include "wpf_params.svh"
// ==========================================================================
// store access
interface wpf_mem_if;
  import wpf_pkg::*;
  logic we;
  wpf_ptr_type waddr;
  wpf_word_type wdata;
  logic [3:0] wstrb;
  wpf_ptr_type raddr;
  wpf_word_type rdata;
  logic [`WPF_NUM_WORDS*32-1:0] image;
  modport ctl (output we, waddr, wdata, wstrb, raddr, input rdata, image);
  modport mem (input we, waddr, wdata, wstrb, raddr, output rdata, image);
endinterface
// ==========================================================================
// received byte stream
interface wpf_rx_if;
  import wpf_pkg::*;
  logic byte_valid;
  logic [7:0] data;
  wpf_index_type index;
  logic frame_end;
  logic multicast;
  logic passed;
  modport src (output byte_valid, data, index, frame_end, multicast, passed);
  modport snk (input byte_valid, data, index, frame_end, multicast, passed);
endinterface

// ==== hw/wpf_store.sv ====
// Purpose: forty-word filter store with registered read data
// Assumes: addresses below forty
// Notes: reserved command bits never store, so they read as zero
`timescale 1ns/1ps
`include "wpf_params.svh"
module wpf_store (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // access
  wpf_mem_if.mem port
);
  import wpf_pkg::*;
  wpf_word_type words [0:`WPF_NUM_WORDS-1];
  wire is_cmd = (port.waddr >= `WPF_CMD_BASE) && (port.waddr < `WPF_OFS_BASE);
  wire wpf_word_type keep = is_cmd ? `WPF_CMD_KEEP : 32'hffffffff;
  wire wpf_word_type lane = {{8{port.wstrb[3]}}, {8{port.wstrb[2]}}, {8{port.wstrb[1]}}, {8{port.wstrb[0]}}};
  wire wpf_word_type merged = (words[port.waddr] & ~lane) | (port.wdata & lane & keep);
  // ==========================================================================
  // storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < `WPF_NUM_WORDS; i++)
        words[i] <= 32'h00000000;
      port.rdata <= 32'h00000000;
    end
    else
    begin
      if (port.we)
        words[port.waddr] <= merged;
      port.rdata <= words[port.raddr];
    end
  end
  genvar g;
  generate
    for (g = 0; g < `WPF_NUM_WORDS; g++)
    begin : g_image
      assign port.image[g*32 +: 32] = words[g];
    end
  endgenerate
endmodule // wpf_store

// ==== hw/wpf_filter.sv ====
// Purpose: one wake pattern engine: masked crc-16 over the frame and match at frame end
// Assumes: index 0 is the first destination address byte; frame_end comes after the last byte
// Notes: crc is msb-first, one byte per cycle
`timescale 1ns/1ps
`include "wpf_params.svh"
module wpf_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // received bytes
  wpf_rx_if.snk rx,
  // filter setting
  input wire logic [`WPF_MASK_BITS-1:0] byte_mask,
  input wire logic [7:0] command,
  input wire logic [7:0] pattern_offset,
  input wire logic [15:0] pattern_crc,
  // result
  output logic wake_match
);
  import wpf_pkg::*;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--)
      r = (r[15] ^ d[b]) ? ({r[14:0], 1'b0} ^ `WPF_CRC_POLY) : {r[14:0], 1'b0};
    return r;
  endfunction
  logic [15:0] crc;
  wire wpf_index_type rel = rx.index - {3'h0, pattern_offset};
  wire in_window = (rx.index >= {3'h0, pattern_offset}) && (rel < 11'd128);
  wire take = in_window && byte_mask[rel[6:0]];
  wire [15:0] base = (rx.index == 11'h000) ? `WPF_CRC_INIT : crc;
  wire scope_ok = command[`WPF_CMD_SCOPE_ANY_BIT] ? rx.passed :
                  (command[`WPF_CMD_SCOPE_MC_BIT] ? rx.multicast : !rx.multicast);
  // ==========================================================================
  // crc and match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      crc <= `WPF_CRC_INIT;
      wake_match <= 1'b0;
    end
    else
    begin
      if (rx.byte_valid)
        crc <= take ? crc_step(base, rx.data) : base;
      wake_match <= rx.frame_end && command[`WPF_CMD_ENABLE_BIT] && scope_ok && (crc == pattern_crc);
    end
  end
endmodule // wpf_filter

// ==== hw/wpf_top.sv ====
// Purpose: wake pattern filter store with axi4-lite access and eight pattern engines
// Assumes: receive strobes synchronous to aclk; one write and one read under way at most
// Notes: the store port walks a word pointer that wraps after the last word
// Notes on behaviour
// - eight filters, 128-bit masks, masks stored first
// - mask words zero to three fill ascending bits
// - mask lsb means earliest received byte
// - set mask bit feeds byte offset+j
// - offsets one byte each, four per word
// - command enable bit and address scope bits
// - eight-bit offset, zero at destination start
// - computed crc equal stored crc flags wake
`timescale 1ns/1ps
`include "wpf_params.svh"
module wpf_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire wpf_pkg::wpf_addr_type s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire wpf_pkg::wpf_word_type s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire wpf_pkg::wpf_addr_type s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output wpf_pkg::wpf_word_type s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // received frame
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_end,
  input wire logic rx_multicast,
  input wire logic rx_passed_filter,
  // wake result, one pulse per matching filter
  output logic [`WPF_NUM_FILTERS-1:0] wake_match
);
  import wpf_pkg::*;

  // ==========================================================================
  // state
  logic aw_full;
  logic w_full;
  wpf_addr_type awaddr_q;
  wpf_word_type wdata_q;
  logic [3:0] wstrb_q;
  wpf_addr_type araddr_q;
  wpf_rd_state_type rd_state;
  wpf_rd_state_type next_rd_state;
  wpf_ptr_type ptr;
  wpf_ptr_type next_ptr;
  logic [`WPF_NUM_FILTERS-1:0] last_match;
  wpf_index_type rx_count;

  wpf_mem_if mem_bus ();
  wpf_rx_if rx_bus ();

  // ==========================================================================
  // write decode
  wire wr_go = aw_full && w_full && !s_axi_bvalid && (rd_state == RD_IDLE);
  wire wr_port = (awaddr_q == `WPF_ADDR_PORT);
  wire wr_ctrl = (awaddr_q == `WPF_ADDR_CTRL);
  wire wr_hit = wr_port || wr_ctrl;
  wire rewind = wr_go && wr_ctrl && wstrb_q[0] && wdata_q[`WPF_CTRL_REWIND_BIT];

  // ==========================================================================
  // read decode
  wire rd_port = (araddr_q == `WPF_ADDR_PORT);
  wire rd_ctrl = (araddr_q == `WPF_ADDR_CTRL);
  wire rd_hit = rd_port || rd_ctrl;
  wire rd_done = (rd_state == RD_FETCH);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wpf_word_type status_word = {16'h0000, last_match, 2'b00, ptr};
  wire wpf_word_type next_rdata = rd_port ? mem_bus.rdata : (rd_ctrl ? status_word : 32'h00000000);

  // ==========================================================================
  // store pointer: every port access moves it one word, so forty accesses cover the store
  wire ptr_step = (wr_go && wr_port) || (rd_done && rd_port);
  wire wpf_ptr_type ptr_inc = (ptr == `WPF_LAST_WORD) ? 6'h00 : ptr + 6'h01;

  always_comb
  begin
    next_ptr = ptr;
    if (rewind)
      next_ptr = 6'h00;
    else if (ptr_step)
      next_ptr = ptr_inc;
  end

  always_comb
  begin
    next_rd_state = rd_state;
    unique case (rd_state)
      RD_IDLE:
        if (ar_take)
          next_rd_state = RD_ADDR;
      RD_ADDR:
        next_rd_state = RD_FETCH;
      RD_FETCH:
        next_rd_state = RD_RESP;
      RD_RESP:
        if (s_axi_rready)
          next_rd_state = RD_IDLE;
    endcase
  end

  assign mem_bus.we = wr_go && wr_port;
  assign mem_bus.waddr = ptr;
  assign mem_bus.wdata = wdata_q;
  assign mem_bus.wstrb = wstrb_q;
  assign mem_bus.raddr = ptr;

  // ==========================================================================
  // write channels: address and data are taken in either order, held until the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WPF_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_full <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_full <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `WPF_RESP_OKAY : `WPF_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // read channels: two wait cycles let the registered store output follow a fresh pointer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state <= RD_IDLE;
      s_axi_arready <= 1'b1;
      araddr_q <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `WPF_RESP_OKAY;
    end
    else
    begin
      rd_state <= next_rd_state;
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        araddr_q <= s_axi_araddr;
      end
      if (rd_done)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_hit ? `WPF_RESP_OKAY : `WPF_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // pointer and match history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr <= 6'h00;
      last_match <= 8'h00;
    end
    else
    begin
      ptr <= next_ptr;
      if (|wake_match)
        last_match <= wake_match;
    end
  end

  // ==========================================================================
  // frame byte index, zero at the first destination address byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_count <= 11'h000;
    else if (rx_frame_end)
      rx_count <= 11'h000;
    else if (rx_byte_valid && (rx_count != `WPF_INDEX_MAX))
      rx_count <= rx_count + 11'h001;
  end

  assign rx_bus.byte_valid = rx_byte_valid;
  assign rx_bus.data = rx_byte;
  assign rx_bus.index = rx_count;
  assign rx_bus.frame_end = rx_frame_end;
  assign rx_bus.multicast = rx_multicast;
  assign rx_bus.passed = rx_passed_filter;

  // ==========================================================================
  // store and engines
  wpf_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(mem_bus)
  );

  genvar f;
  generate
    for (f = 0; f < `WPF_NUM_FILTERS; f++)
    begin : g_filter
      // masks first, four words per filter, word zero in the low bits
      wire [`WPF_MASK_BITS-1:0] mask = mem_bus.image[f*`WPF_MASK_WORDS*32 +: `WPF_MASK_BITS];
      // command, offset and crc words follow the masks
      wire [7:0] cmd = mem_bus.image[(32 + f/4)*32 + (f%4)*8 +: 8];
      wire [7:0] ofs = mem_bus.image[(34 + f/4)*32 + (f%4)*8 +: 8];
      wire [15:0] crc = mem_bus.image[(36 + f/2)*32 + (f%2)*16 +: 16];
      wpf_filter u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx(rx_bus),
        .byte_mask(mask),
        .command(cmd),
        .pattern_offset(ofs),
        .pattern_crc(crc),
        .wake_match(wake_match[f])
      );
    end
  endgenerate
endmodule // wpf_top

// ==== testbench/wpf_checker.sv ====
// Purpose: port checks of the filter store
// Assumes: one clock, reset active low
// Notes: bound at the foot
`timescale 1ns/1ps
module wpf_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire wpf_pkg::wpf_word_type s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // receive side
  input wire logic rx_frame_end,
  input wire logic [7:0] wake_match
);
  import wpf_pkg::*;
  // ==========
  // checks
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // the match lands on the edge right after the end strobe
  a_match_cause: assert property (wake_match != 8'h00 |-> $past(rx_frame_end))
    else $error("match without frame end");
  a_match_pulse: assert property (wake_match != 8'h00 && !rx_frame_end |=> wake_match == 8'h00)
    else $error("match held too long");
  a_read_time: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
    else $error("read answer late");
  a_write_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_arready && !s_axi_arvalid |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rdata == 32'h0)
    else $error("refused read data");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  c_match: cover property (wake_match != 8'h00);
  c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // wpf_checker
bind wpf_top wpf_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .rx_frame_end, .wake_match);

// ==== testbench/wpf_host.sv ====
// Purpose: host driver model issuing register accesses
// Assumes: one access at a time
// Notes: slow holds the answer ready low so the slave must hold
`timescale 1ns/1ps
module wpf_host (
  // clock
  input wire logic aclk,
  // write channels
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output wpf_pkg::wpf_addr_type s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output wpf_pkg::wpf_word_type s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output wpf_pkg::wpf_addr_type s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire wpf_pkg::wpf_word_type s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  import wpf_pkg::*;
  logic hang;
  // lanes of the next write, set by the bench
  logic [3:0] strb;
  initial
  begin
    hang = 1'b0;
    strb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end
  // ==========
  // one access, bounded wait
  task automatic xfer(input logic wr, input wpf_addr_type a, input wpf_word_type d, input logic slow,
    output wpf_word_type q, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_bready <= wr && !slow;
    s_axi_rready <= !wr && !slow;
    for (int n = 0; n < 200 && !done; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      begin
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        done = 1'b1;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
      else if (s_axi_bvalid || s_axi_rvalid)
      begin
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
      end
    end
    hang = !done;
  endtask
endmodule // wpf_host

// ==== testbench/wakeup_pattern_filter_store_bench.sv ====
// Purpose: self-checking bench of the wake pattern filter store
// Assumes: host model drives the register bus
// Notes: random setups from a fixed seed, first round has a hand-set command word
`timescale 1ns/1ps
`include "wpf_params.svh"
module wakeup_pattern_filter_store_bench;
  import wpf_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  wpf_addr_type s_axi_awaddr, s_axi_araddr;
  wpf_word_type s_axi_wdata, s_axi_rdata;
  logic rx_byte_valid, rx_frame_end, rx_multicast, rx_passed_filter;
  logic [7:0] rx_byte, wake_match;
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'd71614;
  wpf_word_type img [40];
  logic [7:0] frame [160];
  // last nonzero wake pattern expected, as the status word should hold it
  logic [7:0] last_e = 8'h00;
  wpf_top i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_byte_valid, .rx_byte,
    .rx_frame_end, .rx_multicast, .rx_passed_filter, .wake_match);
  wpf_host i_host (.aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  // ==========
  // expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] crc_of(input int f);
    logic [15:0] c;
    logic [127:0] m;
    logic [7:0] off;
    c = 16'hffff;
    m = {img[4 * f + 3], img[4 * f + 2], img[4 * f + 1], img[4 * f]};
    off = img[`WPF_OFS_BASE + f / 4][8 * (f % 4) +: 8];
    for (int i = 0; i < 160; i++)
      if (i >= off && i - off < 128 && m[i - off])
      begin
        c ^= {frame[i], 8'h00};
        for (int b = 0; b < 8; b++)
          c = c[15] ? (c << 1) ^ 16'h8005 : c << 1;
      end
    return c;
  endfunction
  function automatic logic wake_of(input int f, input logic mc, input logic pass);
    logic [7:0] cmd;
    cmd = img[`WPF_CMD_BASE + f / 4][8 * (f % 4) +: 8];
    return cmd[0] && (cmd[2] ? pass : cmd[3] == mc) && crc_of(f) == img[36 + f / 2][16 * (f % 2) +: 16];
  endfunction
  // ==========
  // helpers
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input wpf_addr_type a, input wpf_word_type d, output wpf_word_type q,
    output logic [1:0] r);
    i_host.xfer(wr, a, d, rnd() % 3 == 0, q, r);
    if (i_host.hang)
    begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic send(input logic mc, input logic pass);
    logic [7:0] e, got;
    for (int f = 0; f < 8; f++)
      e[f] = wake_of(f, mc, pass);
    if (e != 8'h00)
      last_e = e;
    rx_multicast <= mc;
    rx_passed_filter <= pass;
    for (int i = 0; i < 161; i++)
    begin
      @(posedge aclk);
      rx_byte_valid <= i < 160;
      rx_byte <= frame[i % 160];
      rx_frame_end <= i == 160;
    end
    @(posedge aclk);
    rx_frame_end <= 1'b0;
    #1;
    got = wake_match;
    @(posedge aclk);
    #1;
    check({24'h0, got | wake_match}, {24'h0, e});
  endtask
  // ==========
  // sequence
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    wpf_word_type q;
    logic [1:0] r;
    aresetn = 1'b0;
    {rx_byte_valid, rx_frame_end, rx_multicast, rx_passed_filter, rx_byte} = 12'h000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    acc(0, `WPF_ADDR_PORT, 32'h0, q, r);
    check(q, 32'h0);
    acc(1, 8'h0c, rnd(), q, r);
    check({30'h0, r}, {30'h0, `WPF_RESP_SLVERR});
    acc(0, 8'h08, 32'h0, q, r);
    check({30'h0, r}, {30'h0, `WPF_RESP_SLVERR});
    // lane strobes: only the low half lands, and a rewind without lane zero is ignored
    acc(1, `WPF_ADDR_CTRL, 32'h1, q, r);
    i_host.strb = 4'h3;
    acc(1, `WPF_ADDR_PORT, 32'hffffffff, q, r);
    i_host.strb = 4'he;
    acc(1, `WPF_ADDR_CTRL, 32'h1, q, r);
    i_host.strb = 4'hf;
    acc(0, `WPF_ADDR_CTRL, 32'h0, q, r);
    check(q, 32'h00000001);
    acc(1, `WPF_ADDR_CTRL, 32'h1, q, r);
    acc(0, `WPF_ADDR_PORT, 32'h0, q, r);
    check(q, 32'h0000ffff);
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 160; i++)
        frame[i] = 8'(rnd());
      for (int w = 0; w < 36; w++)
        img[w] = rnd();
      img[32] = k == 0 ? 32'h0d090501 : img[32] & `WPF_CMD_KEEP;
      img[33] &= `WPF_CMD_KEEP;
      img[34] &= 32'h1f1f1f1f;
      img[35] &= 32'h1f1f1f1f;
      // about half the filters get a wrong crc so both outcomes show up
      for (int f = 0; f < 8; f++)
        img[36 + f / 2][16 * (f % 2) +: 16] = crc_of(f) ^ 16'(rnd() % 2);
      acc(1, `WPF_ADDR_CTRL, 32'h1, q, r);
      for (int w = 0; w < 40; w++)
        acc(1, `WPF_ADDR_PORT, w / 2 == 16 ? img[w] | (rnd() & ~`WPF_CMD_KEEP) : img[w], q, r);
      acc(0, `WPF_ADDR_CTRL, 32'h0, q, r);
      check(q, {16'h0000, last_e, 8'h00});
      for (int w = 0; w < 40; w++)
      begin
        acc(0, `WPF_ADDR_PORT, 32'h0, q, r);
        check(q, img[w]);
      end
      send(k[0], k[1]);
    end
    summarize();
  end
endmodule // wakeup_pattern_filter_store_bench
